// *** pkg/irq_wake_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// for the interrupt option and low-power wake block.
// Functional notes
// R1: Option register is write-only; only whole-byte writes are accepted.
// R2: Any reset clears the option register to 00h.
// R3: level_edge_select one gives level mode on source 1, zero gives edge mode.
// R4: edge_polarity_select picks the active edge of source 2.
// R5: global_irq_enable gates maskable sources; source 0 stays able to interrupt.
// R6: With enable zero, source 0 is serviced but never wakes the core.
// R7: With enable zero, WAIT or STOP ends only through reset.
// R8: Bit 7 and bits 3 to 0 of the option register do nothing.
// R9: Timers and slow oscillator to source 3, converter 4, serial 1, masked.
// R10: Port pins go to source 2; supply event gated to source 0.
// R11: WAIT halts fetch only; interrupt resumes with no stabilisation delay.
// R12: STOP needs watchdog off, halts core and oscillator until wake or reset.
// R13: Leaving STOP by interrupt inserts an oscillator stabilisation delay.
// R14: With watchdog active, a STOP request is executed as WAIT.
// R15: Pin or watchdog reset during WAIT or STOP restarts normally.
// R16: From main program, wake services the request then continues.
// R17: From non-maskable routine, wake resumes without servicing the request.
// R18: From maskable routine, maskable wake resumes that routine; pending later.
// R19: Non-maskable wake inside maskable routine runs it first, stays maskable.
// R20: WAIT or STOP is refused while an enabled request is pending.
// R21: Wake-up leaves the oscillator source selection unchanged.
// R22: Source 2 triggers on rising edge when polarity bit one, else falling.
// R23: Source 1 in edge mode triggers on falling edges.
// R24: Edge latch sets on edge, clears when its routine starts; one stored.
// R25: Writes to unused option bits are ignored.
`ifndef IRQ_WAKE_REGS_SVH
`define IRQ_WAKE_REGS_SVH

`define IOPT_ADDR       8'hc8
`define IOPT_RESET      8'h00
`define IOPT_LES_BIT    6
`define IOPT_ESB_BIT    5
`define IOPT_GEN_BIT    4
`define STATUS_ADDR     8'hcc
`define CORE_ADDR       8'hd0
`define OSC_SETTLE_NS   2560000
`define CLK_NS          20
`define OSC_SETTLE_CYC  (`OSC_SETTLE_NS / `CLK_NS)

`endif

// *** pkg/irq_wake_pkg.sv ***
// Types for the interrupt option and low-power wake block.
// Assumes nothing of its surroundings.
package irq_wake_pkg;
  typedef enum logic [3:0] {
    PWR_RUN    = 4'b0001,
    PWR_WAIT   = 4'b0010,
    PWR_STOP   = 4'b0100,
    PWR_SETTLE = 4'b1000
  } pwr_state_t;

  typedef enum logic [1:0] {
    CTX_MAIN  = 2'h0,
    CTX_MASK  = 2'h1,
    CTX_NMI   = 2'h2
  } core_ctx_t;
endpackage

// *** core/sync2.sv ***
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs come from pins outside the clock domain.
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Pins idle high on pull-ups; starting high avoids a false edge
      stage <= '1;
      dout  <= '1;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule

// *** core/edge_latch.sv ***
// Edge detector with a one-deep request latch.
// Assumes a synchronised input and a clear pulse from the core's vector fetch.
module edge_latch (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic level,
  input  wire logic rising,
  input  wire logic clear,
  output logic      pending
);
  logic prev;
  logic hit;

  always_comb begin
    hit = rising ? (level && !prev) : (!level && prev);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  // A new edge in the clear cycle is kept, so set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
    end else if (hit) begin
      pending <= 1'b1; // [R24]
    end else if (clear) begin
      pending <= 1'b0; // [R24]
    end
  end
endmodule

// *** core/irq_wake.sv ***
// Interrupt option register, source routing and WAIT/STOP control.
// Assumes a classic Wishbone master and a core that reports its context.
//
// Our own choice: the Wishbone slave port.
`include "irq_wake_regs.svh"

module irq_wake
  import irq_wake_pkg::*;
#(
  parameter int SETTLE_CYC = `OSC_SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [0:0]  wb_sel_i,
  input  wire logic [7:0]  wb_dat_i,
  output logic      [7:0]  wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        nmiPin,
  input  wire logic        src1Pin,
  input  wire logic [19:0] portPins,
  input  wire logic [19:0] portIrqEnable,
  input  wire logic [1:0]  timer_zero_flag,
  input  wire logic [1:0]  timer_irq_enable,
  input  wire logic        slow_osc_event_flag,
  input  wire logic        slow_osc_irq_enable,
  input  wire logic        convDone,
  input  wire logic        adc_irq_enable,
  input  wire logic        serialDone,
  input  wire logic        serialIrqEnable,
  input  wire logic        supply_event_flag,
  input  wire logic        supply_irq_enable,
  input  wire logic        watchdogActive,
  input  wire logic        waitReq,
  input  wire logic        stopReq,
  input  wire logic        vectorAck,
  input  wire logic [2:0]  vectorAckSrc,
  output logic [4:0]       irqReq,
  output logic             coreHalt,
  output logic             oscStop,
  output logic             sleepRefused,
  output logic             resumeNoService
);
  logic [7:0]  interrupt_option_reg;
  logic        level_edge_select;
  logic        edge_polarity_select;
  logic        global_irq_enable;
  logic        nmiS;
  logic        src1S;
  logic [19:0] portS;
  logic        nmiPend;
  logic        src1Edge;
  logic        src2Pend;
  logic        portAny;
  logic        src1Fall;
  logic [4:0]  raw;
  logic [4:0]  enabled;
  logic        wakeEvent;
  pwr_state_t  pwr;
  pwr_state_t  next_pwr;
  core_ctx_t   ctx;
  core_ctx_t   sleepCtx;
  logic [31:0] settleCnt;
  logic        busReq;
  logic        busWrite;
  logic        hitOpt;
  logic        hitStat;
  logic        hitCore;

  assign level_edge_select    = interrupt_option_reg[`IOPT_LES_BIT]; // [R3]
  assign edge_polarity_select = interrupt_option_reg[`IOPT_ESB_BIT]; // [R4]
  assign global_irq_enable    = interrupt_option_reg[`IOPT_GEN_BIT]; // [R5]

  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] b);
    addr_hit = (a == b);
  endfunction

  // Pins cross into this domain through two flops
  sync2 #(.W(22)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({nmiPin, src1Pin, portPins}),
    .dout   ({nmiS, src1S, portS})
  );

  // Source 0 pin is falling-edge latched like the core's own flip-flop
  edge_latch u_nmi (
    .clk     (clk),
    .arst_n  (arst_n),
    .level   (nmiS),
    .rising  (1'b0),
    .clear   (vectorAck && vectorAckSrc == 3'd0),
    .pending (nmiPend)
  );

  edge_latch u_src1 (
    .clk     (clk),
    .arst_n  (arst_n),
    .level   (src1S),
    .rising  (1'b0), // [R23]
    .clear   (vectorAck && vectorAckSrc == 3'd1),
    .pending (src1Edge)
  );

  assign portAny = |(~portS & portIrqEnable);

  // Port lines share one latch; polarity applies to each enabled line before combining
  edge_latch u_src2 (
    .clk     (clk),
    .arst_n  (arst_n),
    .level   (edge_polarity_select ? |(portS & portIrqEnable) : portAny),
    .rising  (1'b1), // [R22]
    .clear   (vectorAck && vectorAckSrc == 3'd2),
    .pending (src2Pend)
  );

  // Level mode is active low on the line
  assign src1Fall = level_edge_select ? !src1S : src1Edge; // [R3]

  always_comb begin
    raw[0] = nmiPend || (supply_event_flag && supply_irq_enable); // [R10]
    raw[1] = src1Fall || (serialDone && serialIrqEnable); // [R9]
    raw[2] = src2Pend; // [R10]
    raw[3] = |(timer_zero_flag & timer_irq_enable) ||
             (slow_osc_event_flag && slow_osc_irq_enable); // [R9]
    raw[4] = convDone && adc_irq_enable; // [R9]
  end

  assign enabled = {raw[4:1] & {4{global_irq_enable}}, raw[0]}; // [R5]
  // Source 0 counts for wake only when the global enable is set
  assign wakeEvent = global_irq_enable && (|enabled); // [R6] [R7]

  // Context tracked from vector acknowledges and core requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx <= CTX_MAIN;
    end else if (vectorAck) begin
      ctx <= (vectorAckSrc == 3'd0) ? CTX_NMI :
             (ctx == CTX_MAIN) ? CTX_MASK : ctx;
    end else if (busWrite && hitCore) begin
      ctx <= core_ctx_t'(wb_dat_i[1:0]);
    end
  end

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      PWR_RUN: begin
        if ((waitReq || stopReq) && !(|enabled)) begin // [R20]
          if (stopReq && !watchdogActive) begin
            next_pwr = PWR_STOP; // [R12]
          end else begin
            next_pwr = PWR_WAIT; // [R14] [R11]
          end
        end
      end
      PWR_WAIT: begin
        if (wakeEvent) begin
          next_pwr = PWR_RUN; // [R11]
        end
      end
      PWR_STOP: begin
        if (wakeEvent) begin
          next_pwr = PWR_SETTLE; // [R13]
        end
      end
      PWR_SETTLE: begin
        if (settleCnt == 32'(SETTLE_CYC - 1)) begin
          next_pwr = PWR_RUN;
        end
      end
      default: next_pwr = PWR_RUN;
    endcase
  end

  // Reset from pin or watchdog lands here through arst_n
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr <= PWR_RUN; // [R15]
    end else begin
      pwr <= next_pwr;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settleCnt <= '0;
    end else if (pwr == PWR_SETTLE) begin
      settleCnt <= settleCnt + 32'd1;
    end else begin
      settleCnt <= '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleepCtx <= CTX_MAIN;
    end else if (pwr == PWR_RUN && next_pwr != PWR_RUN) begin
      sleepCtx <= ctx;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coreHalt <= 1'b0;
      oscStop  <= 1'b0;
    end else begin
      coreHalt <= next_pwr != PWR_RUN; // [R11] [R12]
      // Only the oscillator run gate; source selection lives elsewhere
      oscStop  <= next_pwr == PWR_STOP; // [R12] [R21]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleepRefused <= 1'b0;
    end else begin
      sleepRefused <= pwr == PWR_RUN && (waitReq || stopReq) &&
                      (|enabled); // [R20]
    end
  end

  // Pulse at resume: set when the core must skip servicing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resumeNoService <= 1'b0;
    end else begin
      resumeNoService <= pwr != PWR_RUN && next_pwr == PWR_RUN &&
                         sleepCtx == CTX_NMI; // [R17]
    end
  end

  // Request vector to the core, priority resolved by the core
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqReq <= '0;
    end else if (ctx == CTX_NMI) begin
      irqReq <= '0; // [R17]
    end else if (ctx == CTX_MASK) begin
      irqReq <= {4'h0, enabled[0]}; // [R18] [R19]
    end else begin
      irqReq <= enabled; // [R16]
    end
  end

  assign busReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the ack edge, while the master still holds the request
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign hitOpt  = addr_hit(wb_adr_i, `IOPT_ADDR);
  assign hitStat = addr_hit(wb_adr_i, `STATUS_ADDR);
  assign hitCore = addr_hit(wb_adr_i, `CORE_ADDR);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_option_reg <= `IOPT_RESET; // [R2]
    end else if (busWrite && hitOpt && wb_sel_i[0]) begin
      // Whole byte only; unused bits never stored
      interrupt_option_reg <= wb_dat_i & 8'h70; // [R1] [R8] [R25]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= busReq && (hitCore || hitStat || (hitOpt && wb_we_i));
      // Reading the write-only register is an error
      wb_err_o <= busReq && !(hitCore || hitStat ||
                              (hitOpt && wb_we_i)); // [R1]
      wb_dat_o <= '0;
      if (busReq && !wb_we_i && hitStat) begin
        wb_dat_o <= {raw, pwr == PWR_STOP || pwr == PWR_SETTLE,
                     pwr == PWR_WAIT, global_irq_enable};
      end else if (busReq && !wb_we_i && hitCore) begin
        wb_dat_o <= {6'h00, ctx};
      end
    end
  end

  a_opt_write: assert property (@(posedge clk) disable iff (!arst_n)
    busWrite && hitOpt && wb_sel_i[0]
    |=> interrupt_option_reg == ($past(wb_dat_i) & 8'h70)) // [R1]
    else $error("option write not stored");
  a_opt_unused: assert property (@(posedge clk) disable iff (!arst_n)
    (interrupt_option_reg & 8'h8f) == 8'h00) // [R8]
    else $error("unused option bits set");
  a_mask_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !global_irq_enable && ctx == CTX_MAIN |=> irqReq[4:1] == 4'h0) // [R5]
    else $error("maskable request passed with enable low");
  a_no_wake: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_WAIT && !global_irq_enable |=> pwr == PWR_WAIT) // [R7]
    else $error("woke with enable low");
  a_wdog_stop: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_RUN && watchdogActive |=> pwr != PWR_STOP) // [R14]
    else $error("stop entered with watchdog active");
  a_wait_fast: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_WAIT && wakeEvent |=> pwr == PWR_RUN && !coreHalt) // [R11]
    else $error("wait exit delayed");
  a_stop_settle: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_STOP && wakeEvent |=> pwr == PWR_SETTLE) // [R13]
    else $error("stop exit skipped settle");
  a_pend_refuse: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_RUN && (waitReq || stopReq) && (|enabled)
    |=> pwr == PWR_RUN && sleepRefused) // [R20]
    else $error("sleep taken with request pending");

  // Multi-step exits are spelled out as sequences
  sequence s_stop_wake;
    pwr == PWR_STOP && wakeEvent;
  endsequence

  sequence s_settle_done;
    pwr == PWR_SETTLE && settleCnt == 32'(SETTLE_CYC - 1);
  endsequence

  sequence s_nmi_resume;
    pwr != PWR_RUN && next_pwr == PWR_RUN && sleepCtx == CTX_NMI;
  endsequence

  a_settle_hold: assert property (@(posedge clk) disable iff (!arst_n)
    s_stop_wake |=> coreHalt && !oscStop) // [R13]
    else $error("core released before oscillator settled");
  a_settle_exit: assert property (@(posedge clk) disable iff (!arst_n)
    s_settle_done |=> pwr == PWR_RUN && !coreHalt) // [R13]
    else $error("settle did not end in run");
  a_nmi_resume: assert property (@(posedge clk) disable iff (!arst_n)
    s_nmi_resume |=> resumeNoService) // [R17]
    else $error("resume from nmi context not flagged");
  a_nmi_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ctx == CTX_NMI |=> irqReq == 5'h00) // [R17]
    else $error("request forwarded in nmi context");
  a_mask_ctx: assert property (@(posedge clk) disable iff (!arst_n)
    ctx == CTX_MASK |=> irqReq[4:1] == 4'h0) // [R18] [R19]
    else $error("maskable request forwarded in maskable context");
  a_stop_osc: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_STOP |-> oscStop) // [R12]
    else $error("oscillator running in stop");
  a_gen_off_stop: assert property (@(posedge clk) disable iff (!arst_n)
    pwr == PWR_STOP && !global_irq_enable |=> pwr == PWR_STOP) // [R7]
    else $error("left stop with enable low");
endmodule

// *** verif/core_model.sv ***
// Behavioural processor core that starts one service routine per enable.
// Assumes registered request outputs from the wake block.
module core_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ackEn,
  input  wire logic [4:0] irqReq,
  input  wire logic       coreHalt,
  output logic            vectorAck,
  output logic [2:0]      vectorAckSrc
);
  logic fired;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vectorAck    <= 1'b0;
      vectorAckSrc <= 3'h0;
      fired        <= 1'b0;
    end else begin
      vectorAck <= 1'b0;
      if (!ackEn) begin
        fired <= 1'b0;
      end else if (!fired && !coreHalt && irqReq != 5'h00) begin
        // One start only, so the bench decides when context changes
        vectorAck <= 1'b1;
        fired     <= 1'b1;
        for (int s = 4; s >= 0; s--) begin
          if (irqReq[s]) vectorAckSrc <= 3'(s);
        end
      end
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the interrupt option and wake block.
// Assumes the register header and the core model beside it.
`include "irq_wake_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ST = 8;
  localparam int SRC [6] = '{3, 3, 3, 4, 1, 0};
  logic        clk = 1'b0;
  logic        arstN = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  wdat = 8'h00;
  logic [7:0]  rd;
  logic [7:0]  d;
  logic [5:0]  evFlag = 6'h00;
  logic [5:0]  evEn = 6'h00;
  logic [19:0] pins = 20'hfffff;
  logic [19:0] pinEn = 20'h00000;
  logic        nmi = 1'b1;
  logic        s1 = 1'b1;
  logic        wdog = 1'b0;
  logic        waitR = 1'b0;
  logic        stopR = 1'b0;
  logic        ackEn = 1'b0;
  logic        berr;
  logic [7:0]  rdat;
  logic        ack, err, halt, oscOff, refused, noSvc, vAck;
  logic [4:0]  irq;
  logic [2:0]  vSrc;
  int          err_total = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  irq_wake #(.SETTLE_CYC(ST)) i_dut (.clk(clk), .arst_n(arstN),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(1'b1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .nmiPin(nmi), .src1Pin(s1), .portPins(pins),
    .portIrqEnable(pinEn), .timer_zero_flag(evFlag[1:0]),
    .timer_irq_enable(evEn[1:0]), .slow_osc_event_flag(evFlag[2]),
    .slow_osc_irq_enable(evEn[2]), .convDone(evFlag[3]),
    .adc_irq_enable(evEn[3]), .serialDone(evFlag[4]),
    .serialIrqEnable(evEn[4]), .supply_event_flag(evFlag[5]),
    .supply_irq_enable(evEn[5]), .watchdogActive(wdog), .waitReq(waitR),
    .stopReq(stopR), .vectorAck(vAck), .vectorAckSrc(vSrc),
    .irqReq(irq), .coreHalt(halt), .oscStop(oscOff),
    .sleepRefused(refused), .resumeNoService(noSvc));
  core_model i_core (.clk(clk), .arst_n(arstN), .ackEn(ackEn),
    .irqReq(irq), .coreHalt(halt), .vectorAck(vAck),
    .vectorAckSrc(vSrc));
  task automatic results();
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkBit(string name, logic exp, logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // Hangs on a silent slave are cut by the cycle ceiling below
  task automatic bus(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge clk); while (!(ack === 1'b1 || err === 1'b1));
    rd = rdat;
    berr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rst();
    arstN <= 1'b0;
    tick(3);
    arstN <= 1'b1;
    bus(0, `STATUS_ADDR, 8'h00);
    chk("reset status", 8'h00, rd & 8'h07);
    chkBit("reset halt", 1'b0, halt);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    void'($urandom(22));
    tick(20);
    arstN <= 1'b1;
    bus(0, `STATUS_ADDR, 8'h00);
    chk("reset status", 8'h00, rd & 8'h07);
    bus(0, `IOPT_ADDR, 8'h00);
    chkBit("option read err", 1'b1, berr);
    bus(0, 8'h3b, 8'h00);
    chkBit("unmapped err", 1'b1, berr);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom());
      bus(1, `IOPT_ADDR, d);
      bus(0, `STATUS_ADDR, 8'h00);
      chkBit("status enable", d[4], rd[0]);
    end
    bus(1, `IOPT_ADDR, 8'hd0); // level mode on source 1, unused bit set
    for (int i = 0; i < 6; i++) begin
      evFlag <= 6'h01 << i;
      tick(6);
      chk("masked request", 8'h00, {3'h0, irq});
      evEn <= 6'h01 << i;
      tick(6);
      chk("routed request", 8'h01 << SRC[i], {3'h0, irq});
      evFlag <= 6'h00;
      evEn <= 6'h00;
      tick(6);
    end
    rst();
    evFlag <= 6'h01;
    evEn <= 6'h01;
    tick(6);
    chk("gated request", 8'h00, {3'h0, irq});
    nmi <= 1'b0;
    tick(6);
    chk("nmi running", 8'h01, {3'h0, irq});
    ackEn <= 1'b1;
    tick(6);
    chk("nmi latch clear", 8'h00, {3'h0, irq});
    ackEn <= 1'b0;
    nmi <= 1'b1;
    bus(1, `CORE_ADDR, 8'h00);
    waitR <= 1'b1;
    tick(4);
    chkBit("wait entered", 1'b1, halt);
    nmi <= 1'b0;
    tick(10);
    chkBit("no wake gen off", 1'b1, halt);
    waitR <= 1'b0;
    nmi <= 1'b1;
    rst();
    bus(1, `IOPT_ADDR, 8'h10);
    tick(6);
    waitR <= 1'b1;
    tick(4);
    chkBit("sleep refused", 1'b1, refused);
    chkBit("no halt pending", 1'b0, halt);
    waitR <= 1'b0;
    evFlag <= 6'h00;
    tick(4);
    for (int k = 0; k < 3; k++) begin
      wdog <= (k == 1);
      waitR <= (k == 0);
      stopR <= (k != 0);
      tick(4);
      chkBit("halted", 1'b1, halt);
      chkBit("osc stopped", k == 2, oscOff);
      evFlag <= 6'h01;
      tick(5);
      chkBit("early resume", k == 2, halt);
      tick(ST + 4);
      chkBit("resumed", 1'b0, halt);
      chkBit("osc running", 1'b0, oscOff);
      waitR <= 1'b0;
      stopR <= 1'b0;
      evFlag <= 6'h00;
      tick(6);
    end
    wdog <= 1'b0;
    bus(1, `CORE_ADDR, 8'h02);
    waitR <= 1'b1;
    tick(4);
    evFlag <= 6'h01;
    tick(2);
    chkBit("resume no service", 1'b1, noSvc);
    chk("nmi ctx quiet", 8'h00, {3'h0, irq});
    waitR <= 1'b0;
    bus(1, `CORE_ADDR, 8'h01);
    tick(4);
    chk("mask ctx hides", 8'h00, {3'h0, irq});
    nmi <= 1'b0;
    tick(6);
    chk("nmi in mask ctx", 8'h01, {3'h0, irq});
    nmi <= 1'b1;
    evFlag <= 6'h00;
    ackEn <= 1'b1;
    tick(4);
    ackEn <= 1'b0;
    bus(1, `CORE_ADDR, 8'h00);
    bus(1, `IOPT_ADDR, 8'h30);
    pinEn <= 20'h00001;
    tick(6);
    // Enabling a high pin in rising mode latches an edge; clear it
    ackEn <= 1'b1;
    tick(4);
    ackEn <= 1'b0;
    bus(1, `CORE_ADDR, 8'h00);
    pins <= 20'hffffe;
    tick(6);
    chk("falling ignored", 8'h00, {3'h0, irq});
    pins <= 20'hfffff;
    tick(6);
    chk("rising taken", 8'h04, {3'h0, irq});
    s1 <= 1'b0;
    tick(6);
    chk("source1 edge", 8'h06, {3'h0, irq});
    s1 <= 1'b1;
    tick(6);
    chk("edge stored", 8'h06, {3'h0, irq});
    rst();
    bus(1, `IOPT_ADDR, 8'h10);
    tick(6);
    chk("no edge after reset", 8'h00, {3'h0, irq});
    pins <= 20'hffffe;
    tick(6);
    chk("falling taken", 8'h04, {3'h0, irq});
    results();
  end
endmodule
